// File: core/carrier_decoder_map.svh
// Address map, field positions and timing counts of the carrier local decoder
`ifndef CARRIER_DECODER_MAP_SVH
`define CARRIER_DECODER_MAP_SVH
`define SRAM_LO 24'h000000
`define SRAM_HI 24'h01ffff
`define PAGE_LO 24'h400000
`define PAGE_HI 24'h7fffff
`define EPROM_HI 24'h47ffff
`define FLASH_LO 24'h480000
`define FLASH_HI 24'h49ffff
`define SHARED_LO 24'hb00000
`define SHARED_HI 24'hbfffff
`define PAGE_CTRL_ADDR 24'hf00000
`define STROBE_CTRL_ADDR 24'hf00002
`define IRQ_STAT_ADDR 24'hf00008
`define DMA_STAT_ADDR 24'hf00009
`define MISC_STAT_ADDR 24'hf0000a
`define BERR_CLR_ADDR 24'hf00028
`define STROBE_TRIG_ADDR 24'hf00038
`define SERIAL_LO 24'hf00040
`define SERIAL_HI 24'hf00043
`define BRIDGE_LO 24'hf00080
`define BRIDGE_HI 24'hf000ff
`define SLOT_BASE 24'hf00400
`define SLOT_ID_OFS 8'h00
`define SLOT_VEC_OFS 8'h40
`define SLOT_IO_OFS 8'h80
`define BR_IMB_LO 4'h0
`define BR_OMB_LO 4'h4
`define BR_FIFO 4'h8
`define HOST_FIFO_OFS 6'h20
`define HOST_OMB_LO 6'h00
`define HOST_IMB_LO 6'h10
`define HOST_SHARED_HI 32'h003fffff
`define HOST_MIN_BASE 32'h00100000
`define PAGE_DEFAULT 8'h00
`define PAGE_FLASH 4'h0
`define PAGE_SLOT_A 4'h1
`define PAGE_SLOT_B 4'h5
`define PAGE_SLOT_C 4'h9
`define PAGE_SLOT_D 4'hd
`define SHARED_MIN_WAIT 3
`define FIFO_DEPTH 8
`endif

// File: core/carrier_decoder_pkg.sv
// Types shared by the carrier local decoder
package carrier_decoder_pkg;
  typedef enum logic [3:0] {
    REG_NONE, REG_SRAM, REG_EPROM, REG_FLASH, REG_SLOT_MEM, REG_SHARED, REG_CTRL,
    REG_SERIAL, REG_BRIDGE, REG_SLOT_ID, REG_SLOT_VEC, REG_SLOT_IO
  } region_e;
  typedef enum logic [1:0] {ARB_IDLE, ARB_HOST, ARB_DSP} arb_e;
endpackage : carrier_decoder_pkg

// File: core/bridge_fifo.sv
// One direction of the bridge data FIFO
`timescale 1ns/1ps
`default_nettype none
module bridge_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (push && !full) wp_d = wp_q + 1'b1;
    if (pop && !empty) rp_d = rp_q + 1'b1;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  always_ff @(posedge clock) begin
    if (push && !full) mem[wp_q[AW-1:0]] <= push_data;
  end
  assign pop_data = mem[rp_q[AW-1:0]];
  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
endmodule : bridge_fifo
`default_nettype wire

// File: core/carrier_local_address_decoder.sv
// Local address decoder, bridge registers and shared memory arbiter of the carrier
// What this block does
// - DSP 0x000000-0x01FFFF selects local SRAM, 32 bits, no wait states.
// - 0x400000-0x7FFFFF is one window: EPROM, flash or slot memory by page.
// - DSP 0xB00000-0xBFFFFF goes straight to shared memory, 32 bits wide.
// - Shared memory DSP access takes at least 3 waits, more during host access.
// - Simultaneous host and DSP requests: host wins, DSP held off.
// - Write at 0xF00028 clears latched bus error flag, stores nothing.
// - Each slot has ID, vector and I/O regions, slots 0x100 apart.
// - 0xF00080-0xF000FF reaches the bridge register set, 32 bits.
// - Bridge holds two independent eight-word 32-bit FIFOs, one each way.
// - Bridge word 0x08: write fills outbound FIFO, read drains inbound FIFO.
// - Four incoming and four outgoing 32-bit mailboxes between host and DSP.
// - Enabled mailbox events raise the bridge interrupt.
// - DSP bridge words: 0-3 incoming, 4-7 outgoing, 8 FIFO, 9-F others.
// - Host registers at 0x00-0x3C: outgoing, incoming mailboxes, FIFO, then status.
// - Host cycles in programmed regions reach bridge registers or shared memory.
// - Host regions lie above 1 Mbyte; shared region spans 0x0-0x3FFFFF.
// - Extra bridge words 0xD (status) and 0xE (interrupt enable) have logic; others read zero.
`timescale 1ns/1ps
`default_nettype none
`include "carrier_decoder_map.svh"
module carrier_local_address_decoder #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH,
  parameter int MIN_WAIT = `SHARED_MIN_WAIT
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic dsp_strobe,
  input wire logic dsp_write,
  input wire logic [23:0] dsp_addr,
  input wire logic [31:0] dsp_wdata,
  output logic [31:0] dsp_rdata,
  output logic dsp_ready,
  output logic sram_select,
  output logic eprom_select,
  output logic flash_select,
  output logic [3:0] slot_memory_select,
  output logic [3:0] slot_id_select,
  output logic [3:0] slot_vector_read,
  output logic [3:0] slot_io_select,
  output logic serial_select,
  output logic shared_select,
  output logic shared_host_owner,
  output logic slots_a_b_wide,
  output logic slots_c_d_wide,
  input wire logic [7:0] slot_irq_pins,
  input wire logic [7:0] slot_dma_pins,
  input wire logic bus_error_event,
  input wire logic [1:0] jumper_pins,
  output logic bus_error_irq,
  output logic strobe_pulse,
  output carrier_decoder_pkg::arb_e arb_state,
  input wire logic host_strobe,
  input wire logic host_write,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic [31:0] host_reg_base,
  input wire logic [31:0] host_shared_base,
  output logic [31:0] host_rdata,
  output logic host_ready,
  output logic mailbox_irq
);
  import carrier_decoder_pkg::*;
  if (MIN_WAIT < 3 || MIN_WAIT > 15) begin : g_bad_wait
    $error("MIN_WAIT must lie between 3 and 15");
  end
  if (FIFO_DEPTH != 8) begin : g_bad_depth
    $error("FIFO_DEPTH must be 8");
  end

  // Pin synchronisers
  logic [7:0] irq_s1, irq_s2, dma_s1, dma_s2;
  logic [1:0] jmp_s1, jmp_s2;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_s1 <= '0;
      irq_s2 <= '0;
      dma_s1 <= '0;
      dma_s2 <= '0;
      jmp_s1 <= '0;
      jmp_s2 <= '0;
    end else begin
      irq_s1 <= slot_irq_pins;
      irq_s2 <= irq_s1;
      dma_s1 <= slot_dma_pins;
      dma_s2 <= dma_s1;
      jmp_s1 <= jumper_pins;
      jmp_s2 <= jmp_s1;
    end
  end

  // Address decode
  logic [7:0] page_q, page_d, strobe_ctl_q, strobe_ctl_d;
  region_e region;
  logic [1:0] slot;
  logic [7:0] slot_ofs;
  always_comb begin
    region = REG_NONE;
    slot = dsp_addr[9:8];
    slot_ofs = {dsp_addr[7:6], 6'h00};
    if (dsp_addr <= `SRAM_HI) region = REG_SRAM;
    else if (dsp_addr >= `PAGE_LO && dsp_addr <= `PAGE_HI) begin
      if (page_q[3:0] != `PAGE_FLASH) region = REG_SLOT_MEM;
      else if (dsp_addr <= `EPROM_HI) region = REG_EPROM;
      else if (dsp_addr >= `FLASH_LO && dsp_addr <= `FLASH_HI) region = REG_FLASH;
    end else if (dsp_addr >= `SHARED_LO && dsp_addr <= `SHARED_HI) region = REG_SHARED;
    else if (dsp_addr >= `BRIDGE_LO && dsp_addr <= `BRIDGE_HI) region = REG_BRIDGE;
    else if (dsp_addr >= `SERIAL_LO && dsp_addr <= `SERIAL_HI) region = REG_SERIAL;
    else if (dsp_addr >= `SLOT_BASE && dsp_addr[23:10] == 14'(`SLOT_BASE >> 10)) begin
      if (slot_ofs == `SLOT_ID_OFS) region = REG_SLOT_ID;
      else if (slot_ofs == `SLOT_VEC_OFS && !dsp_write) region = REG_SLOT_VEC;
      else if (slot_ofs == `SLOT_IO_OFS) region = REG_SLOT_IO;
    end else if (dsp_addr == `PAGE_CTRL_ADDR || dsp_addr == `STROBE_CTRL_ADDR ||
                 dsp_addr == `IRQ_STAT_ADDR || dsp_addr == `DMA_STAT_ADDR ||
                 dsp_addr == `MISC_STAT_ADDR || dsp_addr == `BERR_CLR_ADDR ||
                 dsp_addr == `STROBE_TRIG_ADDR) region = REG_CTRL;
  end

  function automatic logic [3:0] slot_onehot(input logic en, input logic [1:0] s);
    slot_onehot = en ? 4'(4'h1 << s) : 4'h0;
  endfunction : slot_onehot

  function automatic logic [1:0] page_slot(input logic [3:0] p);
    page_slot = p[3:2];
  endfunction : page_slot

  logic page_valid;
  assign page_valid = (page_q[3:0] == `PAGE_SLOT_A) || (page_q[3:0] == `PAGE_SLOT_B) ||
                      (page_q[3:0] == `PAGE_SLOT_C) || (page_q[3:0] == `PAGE_SLOT_D);
  assign sram_select = dsp_strobe && region == REG_SRAM;
  assign eprom_select = dsp_strobe && region == REG_EPROM;
  assign flash_select = dsp_strobe && region == REG_FLASH;
  assign slot_memory_select = slot_onehot(dsp_strobe && region == REG_SLOT_MEM && page_valid,
                                          page_slot(page_q[3:0]));
  assign slot_id_select = slot_onehot(dsp_strobe && region == REG_SLOT_ID, slot);
  assign slot_vector_read = slot_onehot(dsp_strobe && region == REG_SLOT_VEC, slot);
  assign slot_io_select = slot_onehot(dsp_strobe && region == REG_SLOT_IO, slot);
  assign serial_select = dsp_strobe && region == REG_SERIAL;
  assign slots_a_b_wide = page_q[1];
  assign slots_c_d_wide = strobe_ctl_q[1];

  // Shared memory arbitration
  logic host_reg_hit, host_mem_hit, dsp_shared_req;
  logic [31:0] host_ofs;
  assign host_ofs = host_addr - host_shared_base;
  assign host_reg_hit = host_strobe && host_reg_base >= `HOST_MIN_BASE &&
                        host_addr[31:6] == host_reg_base[31:6];
  assign host_mem_hit = host_strobe && host_shared_base >= `HOST_MIN_BASE &&
                        host_addr >= host_shared_base && host_ofs <= `HOST_SHARED_HI;
  assign dsp_shared_req = dsp_strobe && region == REG_SHARED;
  arb_e arb_q, arb_d;
  logic [3:0] wait_q, wait_d;
  always_comb begin
    arb_d = arb_q;
    wait_d = wait_q;
    unique case (arb_q)
      ARB_IDLE: begin
        wait_d = '0;
        if (host_mem_hit) arb_d = ARB_HOST;
        else if (dsp_shared_req) arb_d = ARB_DSP;
      end
      ARB_HOST: begin
        if (!host_mem_hit) arb_d = ARB_IDLE;
      end
      ARB_DSP: begin
        wait_d = wait_q + 1'b1;
        if (!dsp_shared_req) arb_d = ARB_IDLE;
        else if (wait_q == 4'(MIN_WAIT)) arb_d = ARB_IDLE;
      end
    endcase
  end
  assign arb_state = arb_q;
  assign shared_host_owner = arb_q == ARB_HOST;
  assign shared_select = (arb_q == ARB_HOST) || (arb_q == ARB_DSP);

  // Bridge mailboxes and FIFOs
  logic [31:0] in_mb_q [4];
  logic [31:0] out_mb_q [4];
  logic [31:0] in_mb_d [4];
  logic [31:0] out_mb_d [4];
  logic [7:0] mb_full_q, mb_full_d;
  logic [7:0] irq_en_q, irq_en_d;
  logic [3:0] bw;
  logic [3:0] hw;
  logic dsp_br_wr, dsp_br_rd, host_wr, host_rd;
  assign bw = dsp_addr[5:2];
  assign hw = host_addr[5:2];
  assign dsp_br_wr = dsp_strobe && dsp_write && region == REG_BRIDGE;
  assign dsp_br_rd = dsp_strobe && !dsp_write && region == REG_BRIDGE;
  assign host_wr = host_reg_hit && host_write;
  assign host_rd = host_reg_hit && !host_write;
  logic out_full, out_empty, in_full, in_empty;
  logic [31:0] out_data, in_data;
  bridge_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) outbound (
    .clock(clock), .rst_b(rst_b),
    .push(dsp_br_wr && bw == `BR_FIFO), .push_data(dsp_wdata),
    .pop(host_rd && {hw, 2'b00} == `HOST_FIFO_OFS), .pop_data(out_data),
    .full(out_full), .empty(out_empty));
  bridge_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) inbound (
    .clock(clock), .rst_b(rst_b),
    .push(host_wr && {hw, 2'b00} == `HOST_FIFO_OFS), .push_data(host_wdata),
    .pop(dsp_br_rd && bw == `BR_FIFO), .pop_data(in_data),
    .full(in_full), .empty(in_empty));
  always_comb begin
    in_mb_d = in_mb_q;
    out_mb_d = out_mb_q;
    mb_full_d = mb_full_q;
    irq_en_d = irq_en_q;
    // Host fills incoming boxes, DSP fills outgoing ones
    if (dsp_br_rd && bw < `BR_OMB_LO) mb_full_d[bw[1:0]] = 1'b0;
    if (host_wr && hw >= 4'h4 && hw < 4'h8) begin
      in_mb_d[hw[1:0]] = host_wdata;
      mb_full_d[hw[1:0]] = 1'b1;
    end
    if (host_rd && hw < 4'h4) mb_full_d[4 + hw[1:0]] = 1'b0;
    if (dsp_br_wr && bw >= `BR_OMB_LO && bw < `BR_FIFO) begin
      out_mb_d[bw[1:0]] = dsp_wdata;
      mb_full_d[4 + bw[1:0]] = 1'b1;
    end
    if (dsp_br_wr && bw == 4'he) irq_en_d = dsp_wdata[7:0];
  end
  assign mailbox_irq = |(mb_full_q & irq_en_q);

  logic [31:0] host_rdata_d;
  always_comb begin
    host_rdata_d = '0;
    if (hw < 4'h4) host_rdata_d = out_mb_q[hw[1:0]];
    else if (hw < 4'h8) host_rdata_d = in_mb_q[hw[1:0]];
    else if (hw == 4'h8) host_rdata_d = out_data;
    else if (hw == 4'hd) host_rdata_d = {24'h0, mb_full_q};
  end
  assign host_ready = host_reg_hit || (host_mem_hit && arb_q == ARB_HOST);

  // Control registers
  logic berr_q, berr_d, strobe_q, strobe_d;
  always_comb begin
    page_d = page_q;
    strobe_ctl_d = strobe_ctl_q;
    berr_d = berr_q;
    strobe_d = 1'b0;
    if (dsp_strobe && dsp_write && dsp_addr == `PAGE_CTRL_ADDR) page_d = dsp_wdata[7:0];
    if (dsp_strobe && dsp_write && dsp_addr == `STROBE_CTRL_ADDR) strobe_ctl_d = dsp_wdata[7:0];
    if (dsp_strobe && dsp_write && dsp_addr == `BERR_CLR_ADDR) berr_d = 1'b0;
    if (bus_error_event) berr_d = 1'b1;
    if (dsp_strobe && dsp_write && dsp_addr == `STROBE_TRIG_ADDR)
      strobe_d = strobe_ctl_q[0] && !strobe_ctl_q[3];
  end
  assign bus_error_irq = berr_q && strobe_ctl_q[2];
  assign strobe_pulse = strobe_q;

  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    if (region == REG_BRIDGE) begin
      if (bw < `BR_OMB_LO) rdata_d = in_mb_q[bw[1:0]];
      else if (bw < `BR_FIFO) rdata_d = out_mb_q[bw[1:0]];
      else if (bw == `BR_FIFO) rdata_d = in_data;
      else if (bw == 4'hd) rdata_d = {16'h0, out_full, in_empty, 6'h0, mb_full_q};
      else if (bw == 4'he) rdata_d = {24'h0, irq_en_q};
    end else if (dsp_addr == `IRQ_STAT_ADDR) rdata_d = {24'h0, irq_s2};
    else if (dsp_addr == `DMA_STAT_ADDR) rdata_d = {24'h0, dma_s2};
    else if (dsp_addr == `MISC_STAT_ADDR) rdata_d = {29'h0, jmp_s2, berr_q};
  end
  assign dsp_ready = dsp_strobe && (region != REG_SHARED ||
                     (arb_q == ARB_DSP && wait_q == 4'(MIN_WAIT)));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arb_q <= ARB_IDLE;
      wait_q <= '0;
      page_q <= `PAGE_DEFAULT;
      strobe_ctl_q <= '0;
      berr_q <= 1'b0;
      strobe_q <= 1'b0;
      mb_full_q <= '0;
      irq_en_q <= '0;
      dsp_rdata <= '0;
      host_rdata <= '0;
      for (int i = 0; i < 4; i++) begin
        in_mb_q[i] <= '0;
        out_mb_q[i] <= '0;
      end
    end else begin
      arb_q <= arb_d;
      wait_q <= wait_d;
      page_q <= page_d;
      strobe_ctl_q <= strobe_ctl_d;
      berr_q <= berr_d;
      strobe_q <= strobe_d;
      mb_full_q <= mb_full_d;
      irq_en_q <= irq_en_d;
      dsp_rdata <= rdata_d;
      host_rdata <= host_rdata_d;
      in_mb_q <= in_mb_d;
      out_mb_q <= out_mb_d;
    end
  end
endmodule : carrier_local_address_decoder
`default_nettype wire

// File: verif/carrier_decoder_sva.sv
// Checker of decode, arbitration and bus error clearing
`timescale 1ns/1ps
`default_nettype none
module carrier_decoder_sva #(
  parameter int MIN_WAIT = 3
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic dsp_strobe,
  input wire logic dsp_write,
  input wire logic [23:0] dsp_addr,
  input wire logic dsp_ready,
  input wire logic sram_select,
  input wire logic eprom_select,
  input wire logic flash_select,
  input wire logic serial_select,
  input wire logic [3:0] slot_memory_select,
  input wire logic [3:0] slot_id_select,
  input wire logic [3:0] slot_vector_read,
  input wire logic bus_error_event,
  input wire logic bus_error_irq,
  input wire carrier_decoder_pkg::arb_e arb_state,
  input wire logic host_strobe,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_shared_base
);
  import carrier_decoder_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic dsp_sh;
  logic host_sh;
  assign dsp_sh = dsp_strobe && dsp_addr[23:20] == 4'hb;
  assign host_sh = host_strobe && host_shared_base >= 32'h00100000 &&
    host_addr >= host_shared_base && host_addr - host_shared_base <= 32'h003fffff;
  sram_zero_wait_a: assert property (
    dsp_strobe && dsp_addr <= 24'h01ffff |-> sram_select && dsp_ready)
    else $error("sram access not selected at once");
  window_source_a: assert property (
    |slot_memory_select |-> dsp_strobe && dsp_addr[23:22] == 2'b01 &&
    $onehot(slot_memory_select) && !eprom_select && !flash_select)
    else $error("slot memory select outside paged window");
  flash_range_a: assert property (
    flash_select |-> dsp_strobe && dsp_addr >= 24'h480000 && dsp_addr <= 24'h49ffff)
    else $error("flash select outside its range");
  shared_wait_a: assert property (
    dsp_sh && dsp_ready |-> arb_state == ARB_DSP && $past(arb_state, MIN_WAIT) == ARB_DSP)
    else $error("shared access ready too early");
  host_first_a: assert property (
    arb_state == ARB_IDLE && dsp_sh && host_sh |=> arb_state == ARB_HOST)
    else $error("host not granted first");
  host_hold_a: assert property (
    dsp_sh && arb_state == ARB_HOST |-> !dsp_ready)
    else $error("dsp completed while host owns memory");
  berr_clear_a: assert property (
    dsp_strobe && dsp_write && dsp_addr == 24'hf00028 && !bus_error_event |=> !bus_error_irq)
    else $error("bus error flag not cleared");
  slot_id_map_a: assert property (
    |slot_id_select |-> dsp_strobe && dsp_addr[23:10] == 14'h3c01 &&
    dsp_addr[7:6] == 2'b00 && slot_id_select == 4'b0001 << dsp_addr[9:8])
    else $error("slot id select mismatch");
  vector_read_a: assert property (
    |slot_vector_read |-> dsp_strobe && !dsp_write && dsp_addr[7:6] == 2'b01 &&
    slot_vector_read == 4'b0001 << dsp_addr[9:8])
    else $error("vector read select mismatch");
  unmapped_gap_a: assert property (
    dsp_strobe && dsp_addr > 24'h01ffff && dsp_addr < 24'h400000 |-> !sram_select &&
    !eprom_select && !flash_select && !serial_select && slot_memory_select == 4'h0)
    else $error("select active in unmapped range");
endmodule : carrier_decoder_sva
bind carrier_local_address_decoder carrier_decoder_sva #(.MIN_WAIT(MIN_WAIT)) u_sva (
  .clock, .rst_b, .dsp_strobe, .dsp_write, .dsp_addr, .dsp_ready, .sram_select,
  .eprom_select, .flash_select, .serial_select, .slot_memory_select, .slot_id_select,
  .slot_vector_read, .bus_error_event, .bus_error_irq, .arb_state, .host_strobe,
  .host_addr, .host_shared_base);
`default_nettype wire

// File: verif/host_master_model.sv
// Host side master issuing register and shared memory cycles
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
  input wire logic clock,
  input wire logic host_ready,
  input wire logic [31:0] host_rdata,
  output logic host_strobe,
  output logic host_write,
  output logic [31:0] host_addr,
  output logic [31:0] host_wdata
);
  initial begin
    host_strobe = 1'b0;
    host_write = 1'b0;
    host_addr = 32'h0;
    host_wdata = 32'h0;
  end
  // Cycle held until ready, data taken one edge later, then released with lines inverted
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output int n);
    host_strobe = 1'b1;
    host_write = wr;
    host_addr = a;
    host_wdata = d;
    n = 0;
    #1;
    while (host_ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      #1;
      n++;
    end
    @(negedge clock);
    q = host_rdata;
    host_strobe = 1'b0;
    host_write = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
    @(negedge clock);
  endtask : xfer
endmodule : host_master_model
`default_nettype wire

// File: verif/carrier_local_address_decoder_tb.sv
// Testbench of the carrier local address decoder
`timescale 1ns/1ps
`default_nettype none
module carrier_local_address_decoder_tb;
  import carrier_decoder_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, dsp_strobe, dsp_write, bus_error_event;
  logic host_strobe, host_write, dsp_ready, sram_select, eprom_select, flash_select;
  logic serial_select, shared_select, shared_host_owner, slots_a_b_wide, slots_c_d_wide;
  logic bus_error_irq, strobe_pulse, host_ready, mailbox_irq;
  logic [23:0] dsp_addr;
  logic [31:0] dsp_wdata, dsp_rdata, host_addr, host_wdata, host_rdata, q;
  logic [31:0] host_reg_base, host_shared_base;
  logic [3:0] slot_memory_select, slot_id_select, slot_vector_read, slot_io_select;
  logic [7:0] slot_irq_pins, slot_dma_pins;
  logic [1:0] jumper_pins;
  logic [19:0] sel_v;
  arb_e arb_state;
  int errors = 0, checked = 0, pulses = 0, w, w0;
  always #5 clock = ~clock;
  always @(negedge clock) if (strobe_pulse === 1'b1) pulses++;
  carrier_local_address_decoder u_carrier_local_address_decoder (
    .clock, .rst_b, .dsp_strobe, .dsp_write, .dsp_addr, .dsp_wdata, .dsp_rdata, .dsp_ready,
    .sram_select, .eprom_select, .flash_select, .slot_memory_select, .slot_id_select,
    .slot_vector_read, .slot_io_select, .serial_select, .shared_select, .shared_host_owner,
    .slots_a_b_wide, .slots_c_d_wide, .slot_irq_pins, .slot_dma_pins, .bus_error_event,
    .jumper_pins, .bus_error_irq, .strobe_pulse, .arb_state, .host_strobe, .host_write,
    .host_addr, .host_wdata, .host_reg_base, .host_shared_base, .host_rdata, .host_ready,
    .mailbox_irq);
  host_master_model u_host (.clock, .host_ready, .host_rdata, .host_strobe, .host_write,
    .host_addr, .host_wdata);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic dsp_cyc(input logic wr, input logic [23:0] a, input logic [31:0] d);
    int n;
    dsp_strobe = 1'b1;
    dsp_write = wr;
    dsp_addr = a;
    dsp_wdata = d;
    n = 0;
    #1;
    sel_v = {sram_select, eprom_select, flash_select, serial_select, slot_memory_select,
             slot_id_select, slot_vector_read, slot_io_select};
    while (dsp_ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      #1;
      n++;
    end
    if (n == 40) begin
      errors++;
      tally_and_finish();
    end
    w = n;
    @(negedge clock);
    q = dsp_rdata;
    dsp_strobe = 1'b0;
    dsp_write = 1'b0;
    dsp_wdata = ~d;
    @(negedge clock);
  endtask : dsp_cyc
  task automatic host_cyc(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    u_host.xfer(wr, a, d, q, n);
    if (n == 40) begin
      errors++;
      tally_and_finish();
    end
  endtask : host_cyc
  task automatic t_decode;
    logic [23:0] at [10] = '{24'h000000, 24'h01ffff, 24'h020000, 24'h400000, 24'h480000,
                             24'hf00040, 24'hf00400, 24'hf00540, 24'hf00780, 24'h900000};
    logic [19:0] et [10] = '{20'h80000, 20'h80000, 20'h0, 20'h40000, 20'h20000,
                             20'h10000, 20'h00100, 20'h00020, 20'h00008, 20'h0};
    for (int i = 0; i < 10; i++) begin
      dsp_cyc(1'b0, at[i], 32'h0);
      chk(sel_v, et[i]);
    end
    dsp_cyc(1'b1, 24'h000010, 32'h5);
    chk(w, 0);
  endtask : t_decode
  task automatic t_page;
    logic [3:0] pv [4] = '{4'h1, 4'h5, 4'h9, 4'hd};
    for (int i = 0; i < 4; i++) begin
      dsp_cyc(1'b1, 24'hf00000, {28'h0, pv[i]});
      dsp_cyc(1'b0, 24'h400000, 32'h0);
      chk(sel_v, 20'h01000 << i);
    end
    dsp_cyc(1'b1, 24'hf00000, 32'h2);
    chk(slots_a_b_wide, 1'b1);
    dsp_cyc(1'b1, 24'hf00000, 32'h0);
    chk(slots_a_b_wide, 1'b0);
    dsp_cyc(1'b0, 24'h47fff0, 32'h0);
    chk(sel_v, 20'h40000);
  endtask : t_page
  task automatic t_shared;
    dsp_cyc(1'b0, 24'hb00000, 32'h0);
    w0 = w;
    chk(w0 >= 3, 1);
    fork
      host_cyc(1'b1, 32'h00400010, 32'h0);
      dsp_cyc(1'b0, 24'hbffffc, 32'h0);
      begin
        @(posedge clock);
        #1;
        chk(arb_state, ARB_HOST);
        chk(shared_host_owner, 1'b1);
        chk(shared_select, 1'b1);
      end
    join
    chk(w > w0, 1);
  endtask : t_shared
  task automatic t_berr;
    bus_error_event = 1'b1;
    @(negedge clock);
    bus_error_event = 1'b0;
    dsp_cyc(1'b0, 24'hf0000a, 32'h0);
    chk(q[0], 1'b1);
    dsp_cyc(1'b1, 24'hf00002, 32'h4);
    chk(bus_error_irq, 1'b1);
    dsp_cyc(1'b1, 24'hf00028, 32'hff);
    chk(bus_error_irq, 1'b0);
    dsp_cyc(1'b0, 24'hf0000a, 32'h0);
    chk(q[0], 1'b0);
    dsp_cyc(1'b0, 24'hf00008, 32'h0);
    chk(q[7:0], 8'ha5);
    dsp_cyc(1'b0, 24'hf00009, 32'h0);
    chk(q[7:0], 8'h3c);
  endtask : t_berr
  task automatic t_strobe;
    int p;
    p = pulses;
    dsp_cyc(1'b1, 24'hf00002, 32'h3);
    chk(slots_c_d_wide, 1'b1);
    dsp_cyc(1'b1, 24'hf00038, 32'h0);
    repeat (2) @(negedge clock);
    chk(pulses - p, 1);
    dsp_cyc(1'b1, 24'hf00002, 32'h9);
    chk(slots_c_d_wide, 1'b0);
    dsp_cyc(1'b1, 24'hf00038, 32'h0);
    repeat (2) @(negedge clock);
    chk(pulses - p, 1);
  endtask : t_strobe
  task automatic t_mailbox;
    dsp_cyc(1'b1, 24'hf000b8, 32'h1);
    chk(mailbox_irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      dsp_cyc(1'b1, 24'hf00090 + 24'(4 * i), 32'h12345670 + i);
      host_cyc(1'b0, host_reg_base + 32'(4 * i), 32'h0);
      chk(q, 32'h12345670 + i);
      host_cyc(1'b1, host_reg_base + 32'h10 + 32'(4 * i), 32'hcafe0000 + i);
      if (i == 0) chk(mailbox_irq, 1'b1);
      dsp_cyc(1'b0, 24'hf00080 + 24'(4 * i), 32'h0);
      chk(q, 32'hcafe0000 + i);
    end
    chk(mailbox_irq, 1'b0);
  endtask : t_mailbox
  task automatic t_fifo;
    for (int i = 0; i < 9; i++) dsp_cyc(1'b1, 24'hf000a0, 32'h100 + i);
    dsp_cyc(1'b0, 24'hf000b4, 32'h0);
    chk(q[15:14], 2'b11);
    for (int i = 0; i < 8; i++) begin
      host_cyc(1'b0, host_reg_base + 32'h20, 32'h0);
      chk(q, 32'h100 + i);
    end
    for (int i = 0; i < 3; i++) host_cyc(1'b1, host_reg_base + 32'h20, 32'h55aa0000 + i);
    for (int i = 0; i < 3; i++) begin
      dsp_cyc(1'b0, 24'hf000a0, 32'h0);
      chk(q, 32'h55aa0000 + i);
    end
    dsp_cyc(1'b0, 24'hf000b4, 32'h0);
    chk(q[15:14], 2'b01);
  endtask : t_fifo
  initial begin
    dsp_strobe = 1'b0;
    dsp_write = 1'b0;
    dsp_addr = 24'h0;
    dsp_wdata = 32'h0;
    bus_error_event = 1'b0;
    slot_irq_pins = 8'ha5;
    slot_dma_pins = 8'h3c;
    jumper_pins = 2'b01;
    host_reg_base = 32'h00200000;
    host_shared_base = 32'h00400000;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    t_decode();
    t_page();
    t_shared();
    t_berr();
    t_strobe();
    t_mailbox();
    t_fifo();
    tally_and_finish();
  end
endmodule : carrier_local_address_decoder_tb
`default_nettype wire
